// ==== gfs_regs.sv ====
// Register slice: pin override control, frequency counter and link status
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
`include "gfs_defs.svh"

module gfs_regs
#(
  parameter int NGP = 3,
  parameter int OSC_CYC = `GFS_OSC_CYCLES
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Link state from the core
  input wire logic tx_dual_in,
  input wire logic rx_dual_in,
  input wire logic audio_pll_lock_in,
  input wire logic sig_detect_in,
  input wire logic cdr_lock_ch0_in,
  input wire logic cdr_lock_ch1_in,
  // Pixel clock level
  input wire logic pix_clk_in,
  // Pads: index 0 is pin 9, others take their own pairs from outside
  input wire logic [NGP:0] pin_func_out,
  input wire logic [NGP-1:0] oth_dir,
  input wire logic [NGP-1:0] oth_en,
  input wire logic [NGP-1:0] oth_level,
  output logic [NGP:0] pin_out,
  output logic [NGP:0] pin_oe,
  // Interrupt
  output logic irq
);
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] status;
    logic [3:0] ist;
    logic [3:0] mask;
    logic [7:0] rdata;
    logic irq;
    logic [NGP:0] pin_out;
    logic [NGP:0] pin_oe;
  } gfs_top_state_type;

  gfs_top_state_type st_r;
  gfs_top_state_type st_nxt;
  gfs_cnt_if cnt_if ();
  logic pin9_direction;
  logic pin9_enable;
  logic pin9_out_level;
  logic glob_dir;
  logic glob_en;
  logic glob_level;
  logic tx_two_link_flag;
  logic rx_two_link_flag;
  logic lock_live;
  logic [7:0] status_live;
  logic [3:0] events;
  logic [NGP:0] all_dir;
  logic [NGP:0] all_en;
  logic [NGP:0] all_level;
  logic [NGP:0] mux_level;
  logic [NGP:0] mux_oe;
  gfs_pkg::gfs_mode_type glob_mode;

  // ==========================================================
  // Configuration fields
  assign pin9_direction = st_r.cfg[`GFS_CFG_P9DIR_BIT];
  assign pin9_enable = st_r.cfg[`GFS_CFG_P9EN_BIT];
  assign pin9_out_level = st_r.cfg[`GFS_CFG_P9LVL_BIT];
  assign glob_dir = st_r.cfg[`GFS_CFG_GDIR_BIT];
  assign glob_en = st_r.cfg[`GFS_CFG_GEN_BIT];
  assign glob_level = st_r.cfg[`GFS_CFG_GLVL_BIT];
  assign glob_mode = gfs_pkg::gfs_decode(glob_dir, glob_en);

  // ==========================================================
  // Live link status
  assign tx_two_link_flag = tx_dual_in;
  assign rx_two_link_flag = rx_dual_in;
  // Both channels must lock while receiving dual-link
  assign lock_live = cdr_lock_ch0_in & (~rx_dual_in | cdr_lock_ch1_in);
  always_comb
  begin
    status_live = `GFS_STAT_RST;
    status_live[`GFS_STAT_TX_BIT] = tx_two_link_flag;
    status_live[`GFS_STAT_RX_BIT] = rx_two_link_flag;
    status_live[`GFS_STAT_PLL_BIT] = audio_pll_lock_in;
    status_live[`GFS_STAT_SIG_BIT] = sig_detect_in;
    status_live[`GFS_STAT_LOCK_BIT] = lock_live;
  end

  // Events: measurement done and changes of lock, detect, PLL
  always_comb
  begin
    events = 4'h0;
    events[`GFS_IST_DONE_BIT] = cnt_if.done;
    events[`GFS_IST_LOCK_BIT] = status_live[`GFS_STAT_LOCK_BIT] ^ st_r.status[`GFS_STAT_LOCK_BIT];
    events[`GFS_IST_SIG_BIT] = status_live[`GFS_STAT_SIG_BIT] ^ st_r.status[`GFS_STAT_SIG_BIT];
    events[`GFS_IST_PLL_BIT] = status_live[`GFS_STAT_PLL_BIT] ^ st_r.status[`GFS_STAT_PLL_BIT];
  end

  // ==========================================================
  // Frequency counter
  assign cnt_if.start = reg_wr && (reg_addr == `GFS_ADDR_FREQ);
  assign cnt_if.start_val = reg_wdata;
  assign cnt_if.pix_level = pix_clk_in;

  gfs_freq_cnt #(
    .OSC_CYC(OSC_CYC)
  ) u_freq (
    .clock(clock),
    .rst(rst),
    .cif(cnt_if.cnt)
  );

  // ==========================================================
  // Pad muxes, one per pad
  assign all_dir = {oth_dir, pin9_direction};
  assign all_en = {oth_en, pin9_enable};
  assign all_level = {oth_level, pin9_out_level};

  genvar gi;
  generate
    for (gi = 0; gi <= NGP; gi++)
    begin : g_pad
      gfs_pin_mux u_mux (
        .ind_dir(all_dir[gi]),
        .ind_en(all_en[gi]),
        .ind_level(all_level[gi]),
        .glob_dir(glob_dir),
        .glob_en(glob_en),
        .glob_level(glob_level),
        .func_out(pin_func_out[gi]),
        .drv_level(mux_level[gi]),
        .drv_oe(mux_oe[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Bus decode, interrupt and pad registers
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.status = status_live;
    st_nxt.rdata = `GFS_RDATA_RST;
    st_nxt.pin_out = mux_level;
    st_nxt.pin_oe = mux_oe;
    // Sticky events; a read clears, a new event still wins
    st_nxt.ist = st_r.ist | events;
    if (reg_wr)
    begin
      unique case (reg_addr)
        `GFS_ADDR_CFG: st_nxt.cfg = reg_wdata & `GFS_CFG_WMASK;
        `GFS_ADDR_IMASK: st_nxt.mask = reg_wdata[3:0];
        default: st_nxt.cfg = st_r.cfg;
      endcase
    end
    if (reg_rd)
    begin
      unique case (reg_addr)
        `GFS_ADDR_CFG: st_nxt.rdata = st_r.cfg;
        `GFS_ADDR_FREQ: st_nxt.rdata = cnt_if.count;
        `GFS_ADDR_STAT: st_nxt.rdata = st_r.status;
        `GFS_ADDR_IST:
        begin
          st_nxt.rdata = {4'h0, st_r.ist};
          st_nxt.ist = events;
        end
        `GFS_ADDR_IMASK: st_nxt.rdata = {4'h0, st_r.mask};
        default: st_nxt.rdata = `GFS_RDATA_RST;
      endcase
    end
    st_nxt.irq = |(st_nxt.ist & st_nxt.mask);
  end

  // State register
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      st_r.cfg <= `GFS_CFG_RST;
      st_r.status <= `GFS_STAT_RST;
      st_r.ist <= `GFS_IST_RST;
      st_r.mask <= `GFS_IST_RST;
      st_r.rdata <= `GFS_RDATA_RST;
      st_r.irq <= 1'b0;
      st_r.pin_out <= '0;
      st_r.pin_oe <= '0;
    end
    else
      st_r <= st_nxt;
  end

  // Outputs straight from the state register
  assign reg_rdata = st_r.rdata;
  assign pin_out = st_r.pin_out;
  assign pin_oe = st_r.pin_oe;
  assign irq = st_r.irq;

  // ==========================================================
  // Checks on configuration
  cfg_reset_a: assert property (@(posedge clock) $fell(rst) |-> st_r.cfg == `GFS_CFG_RST)
    else $error("config not zero after reset");
  cfg_reserved_a: assert property (@(posedge clock) disable iff (rst)
    st_r.cfg[6] == 1'b0 && st_r.cfg[2] == 1'b0)
    else $error("reserved config bit set");
  cfg_write_a: assert property (@(posedge clock) disable iff (rst)
    (reg_wr && reg_addr == `GFS_ADDR_CFG) |=> st_r.cfg == ($past(reg_wdata) & `GFS_CFG_WMASK))
    else $error("config write lost");

  // Checks on pads
  pin9_gpio_a: assert property (@(posedge clock) disable iff (rst)
    (!pin9_direction && pin9_enable) |=> (pin_oe[0] && pin_out[0] == $past(pin9_out_level)))
    else $error("pin 9 level not driven");
  ind_prior_a: assert property (@(posedge clock) disable iff (rst)
    (pin9_direction && pin9_enable && glob_mode == gfs_pkg::GFS_GP_OUT) |=> !pin_oe[0])
    else $error("global overrode pin 9");
  glob_level_a: assert property (@(posedge clock) disable iff (rst)
    (!oth_dir[0] && !oth_en[0] && !glob_dir && glob_en)
    |=> (pin_oe[1] && pin_out[1] == $past(glob_level)))
    else $error("global level not driven");
  glob_tri_a: assert property (@(posedge clock) disable iff (rst)
    (!oth_dir[0] && !oth_en[0] && glob_dir) |=> !pin_oe[1])
    else $error("global release ignored");
  glob_func_a: assert property (@(posedge clock) disable iff (rst)
    (!oth_dir[0] && !oth_en[0] && !glob_dir && !glob_en)
    |=> (pin_oe[1] && pin_out[1] == $past(pin_func_out[1])))
    else $error("functional drive lost");

  // Checks on counter and status reads
  start_write_a: assert property (@(posedge clock) disable iff (rst)
    (reg_wr && reg_addr == `GFS_ADDR_FREQ) |=> (cnt_if.busy || cnt_if.done))
    else $error("write did not start count");
  freq_read_a: assert property (@(posedge clock) disable iff (rst)
    (reg_rd && reg_addr == `GFS_ADDR_FREQ) |=> reg_rdata == $past(cnt_if.count))
    else $error("count read wrong");
  stat_mode_a: assert property (@(posedge clock) disable iff (rst)
    (reg_rd && reg_addr == `GFS_ADDR_STAT) ##1 !$past(rst, 2)
    |-> (reg_rdata[5] == $past(tx_dual_in, 2) && reg_rdata[4] == $past(rx_dual_in, 2)))
    else $error("link mode status wrong");
  stat_misc_a: assert property (@(posedge clock) disable iff (rst)
    (reg_rd && reg_addr == `GFS_ADDR_STAT) ##1 !$past(rst, 2)
    |-> (reg_rdata[3] == $past(audio_pll_lock_in, 2) && reg_rdata[1] == $past(sig_detect_in, 2)))
    else $error("pll or detect status wrong");
  stat_lock_a: assert property (@(posedge clock) disable iff (rst)
    (reg_rd && reg_addr == `GFS_ADDR_STAT) ##1 !$past(rst, 2)
    |-> (reg_rdata[0] == $past(lock_live, 2) && reg_rdata[7:6] == 2'b00 && reg_rdata[2] == 1'b0))
    else $error("lock status wrong");
endmodule

// ==== gfs_defs.svh ====
// Offsets, field positions, reset values and timing counts of the register slice
`ifndef GFS_DEFS_SVH
`define GFS_DEFS_SVH
// ==========================================================
// Register offsets
`define GFS_ADDR_CFG 8'h1A
`define GFS_ADDR_FREQ 8'h1B
`define GFS_ADDR_STAT 8'h1C
`define GFS_ADDR_IST 8'h20
`define GFS_ADDR_IMASK 8'h21
// ==========================================================
// Global and pin 9 configuration fields
`define GFS_CFG_GLVL_BIT 7
`define GFS_CFG_GDIR_BIT 5
`define GFS_CFG_GEN_BIT 4
`define GFS_CFG_P9LVL_BIT 3
`define GFS_CFG_P9DIR_BIT 1
`define GFS_CFG_P9EN_BIT 0
`define GFS_CFG_WMASK 8'hBB
`define GFS_CFG_RST 8'h00
// ==========================================================
// Link status fields
`define GFS_STAT_TX_BIT 5
`define GFS_STAT_RX_BIT 4
`define GFS_STAT_PLL_BIT 3
`define GFS_STAT_SIG_BIT 1
`define GFS_STAT_LOCK_BIT 0
`define GFS_STAT_RST 8'h00
// ==========================================================
// Interrupt status and mask fields
`define GFS_IST_DONE_BIT 0
`define GFS_IST_LOCK_BIT 1
`define GFS_IST_SIG_BIT 2
`define GFS_IST_PLL_BIT 3
`define GFS_IST_RST 4'h0
`define GFS_RDATA_RST 8'h00
// ==========================================================
// Frequency counter and timing
`define GFS_CNT_MAX 8'hFF
`define GFS_CNT_RST 8'h00
`define GFS_OSC_PERIOD_NS 50
`define GFS_CLK_PERIOD_NS 5
`define GFS_OSC_CYCLES ((`GFS_OSC_PERIOD_NS + `GFS_CLK_PERIOD_NS - 1) / `GFS_CLK_PERIOD_NS)
`endif

// ==== gfs_pkg.sv ====
// Types shared by the register slice modules
package gfs_pkg;
  // ==========================================================
  // Pad mode decoded from a direction and enable pair
  typedef enum logic [1:0] {GFS_FUNC_OUT, GFS_TRISTATE, GFS_GP_OUT, GFS_GP_IN} gfs_mode_type;

  // Frequency counter state
  typedef struct packed {
    logic busy;
    logic done;
    logic pix_q;
    logic [7:0] rem;
    logic [7:0] cnt;
    logic [7:0] div;
  } gfs_cnt_state_type;

  // Pair decode: direction first, enable second
  function automatic gfs_mode_type gfs_decode(input logic dir, input logic en);
    gfs_mode_type m;
    m = GFS_FUNC_OUT;
    unique case ({dir, en})
      2'b00: m = GFS_FUNC_OUT;
      2'b10: m = GFS_TRISTATE;
      2'b01: m = GFS_GP_OUT;
      2'b11: m = GFS_GP_IN;
    endcase
    return m;
  endfunction
endpackage

// ==== gfs_cnt_if.sv ====
// Link between the register bank and the frequency counter
`timescale 1ns/100ps
interface gfs_cnt_if;
  logic start;
  logic [7:0] start_val;
  logic pix_level;
  logic [7:0] count;
  logic busy;
  logic done;
  modport ctl (output start, start_val, pix_level, input count, busy, done);
  modport cnt (input start, start_val, pix_level, output count, busy, done);
endinterface

// ==== gfs_pin_mux.sv ====
// Per-pad selection between individual, global and functional drive
`timescale 1ns/100ps
module gfs_pin_mux
(
  // Individual pair and level
  input wire logic ind_dir,
  input wire logic ind_en,
  input wire logic ind_level,
  // Global pair and level
  input wire logic glob_dir,
  input wire logic glob_en,
  input wire logic glob_level,
  // Core function
  input wire logic func_out,
  // Pad drive
  output logic drv_level,
  output logic drv_oe
);
  gfs_pkg::gfs_mode_type ind_mode;
  gfs_pkg::gfs_mode_type glob_mode;

  // ==========================================================
  // Decode both pairs
  assign ind_mode = gfs_pkg::gfs_decode(ind_dir, ind_en);
  assign glob_mode = gfs_pkg::gfs_decode(glob_dir, glob_en);

  // Individual setting wins unless it is plain functional
  always_comb
  begin
    drv_level = 1'b0;
    drv_oe = 1'b0;
    unique case (ind_mode)
      gfs_pkg::GFS_GP_OUT:
      begin
        drv_level = ind_level;
        drv_oe = 1'b1;
      end
      gfs_pkg::GFS_GP_IN, gfs_pkg::GFS_TRISTATE:
      begin
        drv_oe = 1'b0;
      end
      gfs_pkg::GFS_FUNC_OUT:
      begin
        unique case (glob_mode)
          gfs_pkg::GFS_FUNC_OUT:
          begin
            drv_level = func_out;
            drv_oe = 1'b1;
          end
          gfs_pkg::GFS_GP_OUT:
          begin
            drv_level = glob_level;
            drv_oe = 1'b1;
          end
          gfs_pkg::GFS_TRISTATE, gfs_pkg::GFS_GP_IN:
          begin
            drv_oe = 1'b0;
          end
        endcase
      end
    endcase
  end
endmodule

// ==== gfs_freq_cnt.sv ====
// Pixel clock edge counter over an interval of oscillator periods
`timescale 1ns/100ps
`include "gfs_defs.svh"
module gfs_freq_cnt
#(
  parameter int OSC_CYC = `GFS_OSC_CYCLES
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control link
  gfs_cnt_if.cnt cif
);
  localparam logic [7:0] OSC_LAST = 8'(OSC_CYC - 1);
  gfs_pkg::gfs_cnt_state_type st_r;
  gfs_pkg::gfs_cnt_state_type st_nxt;
  logic pix_edge;
  logic [15:0] el_r;
  logic [7:0] val_r;

  // ==========================================================
  // Counter sequence
  assign pix_edge = cif.pix_level & ~st_r.pix_q;
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.pix_q = cif.pix_level;
    st_nxt.done = 1'b0;
    if (cif.start)
    begin
      st_nxt.busy = (cif.start_val != 8'h00);
      st_nxt.done = (cif.start_val == 8'h00);
      st_nxt.rem = cif.start_val;
      st_nxt.div = 8'h00;
      st_nxt.cnt = `GFS_CNT_RST;
    end
    else if (st_r.busy)
    begin
      if (pix_edge && st_r.cnt != `GFS_CNT_MAX)
        st_nxt.cnt = st_r.cnt + 8'h01;
      if (st_r.div == OSC_LAST)
      begin
        st_nxt.div = 8'h00;
        st_nxt.rem = st_r.rem - 8'h01;
        if (st_r.rem == 8'h01)
        begin
          st_nxt.busy = 1'b0;
          st_nxt.done = 1'b1;
        end
      end
      else
        st_nxt.div = st_r.div + 8'h01;
    end
  end

  // State register
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // Outputs to the bank
  assign cif.count = st_r.cnt;
  assign cif.busy = st_r.busy;
  assign cif.done = st_r.done;

  // ==========================================================
  // Helper: elapsed busy cycles and written value
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      el_r <= 16'h0000;
      val_r <= 8'h00;
    end
    else if (cif.start)
    begin
      el_r <= 16'h0000;
      val_r <= cif.start_val;
    end
    else if (st_r.busy)
      el_r <= el_r + 16'h0001;
  end

  interval_len_a: assert property (@(posedge clock) disable iff (rst)
    st_r.done |-> el_r == 16'(val_r * OSC_CYC))
    else $error("interval length wrong");
  count_sat_a: assert property (@(posedge clock) disable iff (rst)
    (st_r.busy && st_r.cnt == `GFS_CNT_MAX && !cif.start) |=> st_r.cnt == `GFS_CNT_MAX)
    else $error("count wrapped");
endmodule

// ==== gfs_regs_tb.sv ====
// Self-checking bench for the register slice
`timescale 1ns/100ps
`include "gfs_defs.svh"
module gfs_regs_tb;
  localparam int OSC = 4;
  // ==========================================================
  // Design signals
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic tx_dual_in = 1'b0;
  logic rx_dual_in = 1'b0;
  logic audio_pll_lock_in = 1'b0;
  logic sig_detect_in = 1'b0;
  logic cdr_lock_ch0_in = 1'b0;
  logic cdr_lock_ch1_in = 1'b0;
  logic pix_clk_in = 1'b0;
  logic [3:0] pin_func_out = 4'hA;
  logic [2:0] oth_dir = 3'h0;
  logic [2:0] oth_en = 3'h0;
  logic [2:0] oth_level = 3'h0;
  logic [3:0] pin_out;
  logic [3:0] pin_oe;
  logic irq;
  // ==========================================================
  // Bench state
  int miscompares = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'h00001C19;
  logic [15:0] exp_q[$];
  logic [15:0] note;
  logic rd_q = 1'b0;

  gfs_regs #(.NGP(3), .OSC_CYC(OSC)) u_gfs_regs (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_dual_in(tx_dual_in), .rx_dual_in(rx_dual_in), .audio_pll_lock_in(audio_pll_lock_in),
    .sig_detect_in(sig_detect_in), .cdr_lock_ch0_in(cdr_lock_ch0_in), .cdr_lock_ch1_in(cdr_lock_ch1_in),
    .pix_clk_in(pix_clk_in), .pin_func_out(pin_func_out), .oth_dir(oth_dir), .oth_en(oth_en),
    .oth_level(oth_level), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));

  // Clock at 200 MHz
  initial
  begin
    forever #2.5 clock = ~clock;
  end

  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Expected pad drive as {oe, level}
  function automatic logic [1:0] pad(input logic [1:0] own, input logic lvl, input logic [1:0] g,
                                     input logic gl, input logic f);
    if (own == 2'b01)
      return {1'b1, lvl};
    if (own != 2'b00)
      return 2'b00;
    if (g == 2'b00)
      return {1'b1, f};
    if (g == 2'b01)
      return {1'b1, gl};
    return 2'b00;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Bus cycles: one-cycle strobe, then one idle edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask

  // Read notes the expected value and compare mask for the watcher
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back({m, e});
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
  endtask

  // Pixel clock pulses, one rising edge per two cycles
  task automatic pulse(input int n);
    repeat (n)
    begin
      pix_clk_in <= 1'b1;
      @(posedge clock);
      pix_clk_in <= 1'b0;
      @(posedge clock);
    end
  endtask

  // Bounded wait for the interrupt, counting edges
  task automatic wait_irq(output int n);
    n = 0;
    while (irq !== 1'b1)
    begin
      @(posedge clock);
      n++;
      if (n > 3000)
      begin
        miscompares++;
        report_and_stop();
      end
    end
  endtask

  // Read result watcher: answer stands in the cycle after the strobe
  always @(posedge clock)
  begin
    if (rd_q && exp_q.size() > 0)
    begin
      note = exp_q.pop_front();
      check({8'h00, reg_rdata & note[15:8]}, {8'h00, note[7:0] & note[15:8]});
    end
    rd_q = reg_rd;
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    int n;
    logic [31:0] r;
    logic [7:0] cfg;
    logic [3:0] eoe;
    logic [3:0] eout;
    logic [1:0] pe;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    wait_n(3);
    check({12'h000, pin_oe}, 16'h000F);
    check({12'h000, pin_out}, 16'h000A);
    rd(`GFS_ADDR_CFG, 8'h00, 8'hFF);
    rd(`GFS_ADDR_FREQ, 8'h00, 8'hFF);
    rd(`GFS_ADDR_STAT, 8'h00, 8'hFF);
    rd(8'h30, 8'h00, 8'hFF);
    // Every global and pin 9 pair against random own pairs of other pads
    for (int i = 0; i < 32; i++)
    begin
      r = rnd();
      cfg = {r[7], r[6], i[3:2], r[3], r[2], i[1:0]};
      oth_dir <= r[10:8];
      oth_en <= r[13:11];
      oth_level <= r[16:14];
      pin_func_out <= r[20:17];
      wr(`GFS_ADDR_CFG, cfg);
      rd(`GFS_ADDR_CFG, cfg & 8'hBB, 8'hFF);
      pe = pad(cfg[1:0], cfg[3], cfg[5:4], cfg[7], r[17]);
      eoe[0] = pe[1];
      eout[0] = pe[0];
      for (int k = 1; k < 4; k++)
      begin
        pe = pad({r[7+k], r[10+k]}, r[13+k], cfg[5:4], cfg[7], r[17+k]);
        eoe[k] = pe[1];
        eout[k] = pe[0];
      end
      check({12'h000, pin_oe}, {12'h000, eoe});
      check({12'h000, pin_out}, {12'h000, eout});
    end
    // Masked completion stays sticky but quiet
    rd(`GFS_ADDR_IST, 8'h00, 8'h00);
    wr(`GFS_ADDR_FREQ, 8'h01);
    wait_n(OSC + 6);
    check({15'h0000, irq}, 16'h0000);
    rd(`GFS_ADDR_IST, 8'h01, 8'hFF);
    rd(`GFS_ADDR_IST, 8'h00, 8'hFF);
    wr(`GFS_ADDR_IMASK, 8'h01);
    rd(`GFS_ADDR_IMASK, 8'h01, 8'hFF);
    // Interval length for zero and a short value
    for (int i = 0; i < 2; i++)
    begin
      wr(`GFS_ADDR_FREQ, 8'(i * 5));
      wait_irq(n);
      check(n[15:0], 16'(i * 5 * OSC + 1));
      rd(`GFS_ADDR_FREQ, 8'h00, 8'hFF);
      rd(`GFS_ADDR_IST, 8'h01, 8'hFF);
      check({15'h0000, irq}, 16'h0000);
    end
    // Restart in mid-run clears the count; edges after the interval are ignored
    wr(`GFS_ADDR_FREQ, 8'hFF);
    pulse(20);
    wr(`GFS_ADDR_FREQ, 8'd100);
    fork
      pulse(30);
      wait_irq(n);
    join
    check(n[15:0], 16'(100 * OSC + 1));
    rd(`GFS_ADDR_FREQ, 8'd30, 8'hFF);
    pulse(10);
    rd(`GFS_ADDR_FREQ, 8'd30, 8'hFF);
    rd(`GFS_ADDR_IST, 8'h01, 8'hFF);
    // Saturation past the top of the count
    wr(`GFS_ADDR_FREQ, 8'hFF);
    pulse(300);
    wait_irq(n);
    rd(`GFS_ADDR_FREQ, 8'hFF, 8'hFF);
    rd(`GFS_ADDR_IST, 8'h01, 8'hFF);
    // Every combination of link state inputs
    for (int i = 0; i < 64; i++)
    begin
      {tx_dual_in, rx_dual_in, audio_pll_lock_in, sig_detect_in, cdr_lock_ch0_in, cdr_lock_ch1_in} <= i[5:0];
      wait_n(3);
      rd(`GFS_ADDR_STAT, {2'b00, i[5:3], 1'b0, i[2], i[1] & (~i[4] | i[0])}, 8'hFF);
    end
    wr(`GFS_ADDR_STAT, 8'hFF);
    rd(`GFS_ADDR_STAT, 8'h3B, 8'hFF);
    // Detect change raises the interrupt once unmasked
    rd(`GFS_ADDR_IST, 8'h00, 8'h00);
    wr(`GFS_ADDR_IMASK, 8'h04);
    sig_detect_in <= 1'b0;
    wait_n(4);
    check({15'h0000, irq}, 16'h0001);
    rd(`GFS_ADDR_IST, 8'h04, 8'h04);
    check({15'h0000, irq}, 16'h0000);
    wait_n(3);
    report_and_stop();
  end
endmodule
